// File: verilog/periph_move_pkg.sv
package periph_move_pkg;
    localparam logic [2:0]  MOVE_OP_CODE   = 3'h3;
    localparam logic [7:0]  BANK_OP_CODE   = 8'hB8;
    localparam logic [7:0]  BANK_RESET     = 8'h00;
    localparam logic [7:0]  WORK_ADDR      = 8'h0A;
    localparam logic [7:0]  INDF0_ADDR     = 8'h00;
    localparam logic [7:0]  INDF1_ADDR     = 8'h08;
    localparam int          MOVE_HI_POS    = 13;
    localparam int          DEST_LSB_POS   = 8;

    typedef enum logic [3:0] {
        Q1 = 4'b0001,
        Q2 = 4'b0010,
        Q3 = 4'b0100,
        Q4 = 4'b1000
    } qphase_t;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } mem_req_t;

    typedef struct packed {
        qphase_t    phase;
        logic [1:0] kind;
        logic [7:0] src;
        logic [7:0] dst;
        logic [7:0] lit;
        logic [7:0] data;
        logic [7:0] bank;
        logic       done;
    } exec_state_t;
endpackage

// File: verilog/addr_resolve.sv
`timescale 1ns/1ps
`default_nettype none
// Replaces an indirect-window address by the matching pointer value
module addr_resolve
    import periph_move_pkg::*;
(
    input  wire logic [7:0] raw_addr,
    input  wire logic [7:0] fsr0,
    input  wire logic [7:0] fsr1,
    output logic      [7:0] eff_addr
);
    // Indirect selection through either pointer
    always_comb begin
        if (raw_addr == INDF0_ADDR) begin
            eff_addr = fsr0;
        end else if (raw_addr == INDF1_ADDR) begin
            eff_addr = fsr1;
        end else begin
            eff_addr = raw_addr;
        end
    end
endmodule
`default_nettype wire

// File: verilog/file_periph_move_bank_low_exec.sv
`timescale 1ns/1ps
`default_nettype none
// Executes the file-to-peripheral move and the bank-low nibble load
module file_periph_move_bank_low_exec
    import periph_move_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic [7:0]  fsr0,
    input  wire logic [7:0]  fsr1,
    input  wire logic [7:0]  rd_data,
    output var mem_req_t     rd_req,
    output var mem_req_t     wr_req,
    output logic      [7:0]  bank_select_reg,
    output logic      [3:0]  q_phase,
    output logic             instr_done,
    output logic             flags_we
);
    localparam logic [1:0] KIND_NONE = 2'h0;
    localparam logic [1:0] KIND_MOVE = 2'h1;
    localparam logic [1:0] KIND_BANK = 2'h2;

    exec_state_t s_q;
    exec_state_t s_d;
    logic        is_move;
    logic        is_bank;
    logic [7:0]  src_raw;
    logic [7:0]  dst_raw;
    logic [7:0]  src_eff;
    logic [7:0]  dst_eff;

    // Decode of the fetched word
    assign is_move = instr_valid && (instr_word[15:MOVE_HI_POS] == MOVE_OP_CODE);
    assign is_bank = instr_valid && (instr_word[15:8] == BANK_OP_CODE);
    assign src_raw = instr_word[7:0];
    assign dst_raw = {3'h0, instr_word[12:DEST_LSB_POS]};

    // Operand resolution; working register passes as a plain address
    addr_resolve u_src (
        .raw_addr (src_raw),
        .fsr0     (fsr0),
        .fsr1     (fsr1),
        .eff_addr (src_eff)
    );
    addr_resolve u_dst (
        .raw_addr (dst_raw),
        .fsr0     (fsr0),
        .fsr1     (fsr1),
        .eff_addr (dst_eff)
    );

    // Quarter-cycle sequencing
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        unique case (s_q.phase)
            // Decode slot: capture kind and resolved operands
            Q1: begin
                s_d.phase = Q2;
                s_d.kind  = is_move ? KIND_MOVE : (is_bank ? KIND_BANK : KIND_NONE);
                s_d.src   = src_eff;
                s_d.dst   = dst_eff;
                s_d.lit   = {4'h0, instr_word[3:0]};
            end
            // Read slot: latch the source byte
            Q2: begin
                s_d.phase = Q3;
                if (s_q.kind == KIND_MOVE) begin
                    s_d.data = rd_data;
                end
            end
            // Process slot: data passes unchanged
            Q3: begin
                s_d.phase = Q4;
            end
            // Write slot: bank nibble update and completion
            Q4: begin
                s_d.phase = Q1;
                s_d.done  = (s_q.kind != KIND_NONE);
                if (s_q.kind == KIND_BANK) begin
                    s_d.bank = {s_q.bank[7:4], s_q.lit[3:0]};
                end
            end
            default: s_d.phase = Q1;
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_q <= '{
                phase: Q1,
                kind:  KIND_NONE,
                src:   8'h00,
                dst:   8'h00,
                lit:   8'h00,
                data:  8'h00,
                bank:  BANK_RESET,
                done:  1'b0
            };
        end else begin
            s_q <= s_d;
        end
    end

    // Memory strobes in Q2 and Q4
    always_comb begin
        rd_req      = '0;
        wr_req      = '0;
        rd_req.en   = (s_q.phase == Q2) && (s_q.kind == KIND_MOVE);
        rd_req.addr = s_q.src;
        wr_req.en   = (s_q.phase == Q4) && (s_q.kind == KIND_MOVE);
        wr_req.addr = s_q.dst;
        wr_req.data = s_q.data;
    end

    assign bank_select_reg = s_q.bank;
    assign q_phase         = s_q.phase;
    assign instr_done      = s_q.done;
    assign flags_we        = 1'b0;

    // Checks

    // Byte read in Q2 is the byte written in Q4
    chk_move_write_data: assert property (@(posedge clk) disable iff (!reset_n)
        rd_req.en |-> ##2 (wr_req.en && wr_req.data == $past(rd_data, 2)))
        else $error("move wrote wrong data");

    // Read strobe only in the second quarter
    chk_read_in_q2: assert property (@(posedge clk) disable iff (!reset_n)
        rd_req.en |-> q_phase == 4'b0010) else $error("read outside Q2");

    // Write strobe only in the fourth quarter
    chk_write_in_q4: assert property (@(posedge clk) disable iff (!reset_n)
        wr_req.en |-> q_phase == 4'b1000) else $error("write outside Q4");

    // Direct destinations stay inside the lower window
    chk_dest_window: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_req.en && $past(q_phase, 3) == 4'b0001 && $past(instr_word[12:8] != 5'h08, 3)
         && $past(instr_word[12:8] != 5'h00, 3)) |-> wr_req.addr < 8'h20)
        else $error("destination outside window");

    // High nibble of bank select never moves
    chk_bank_high_keep: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) |-> bank_select_reg[7:4] == $past(bank_select_reg[7:4]))
        else $error("bank high nibble changed");

    // Literal lands in the low nibble at the end of the round
    chk_bank_low_load: assert property (@(posedge clk) disable iff (!reset_n)
        (q_phase == 4'b0001 && is_bank) |-> ##4 bank_select_reg[3:0] == $past(instr_word[3:0], 4))
        else $error("bank low nibble not loaded");

    // Status flag write enable stays low
    chk_no_flags: assert property (@(posedge clk) disable iff (!reset_n)
        !flags_we) else $error("status flags written");

    // A recognised word completes after one round
    chk_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
        (q_phase == 4'b0001 && (is_move || is_bank)) |-> ##4 instr_done)
        else $error("instruction not done in one cycle");

    // Source through the first pointer
    chk_indirect_src: assert property (@(posedge clk) disable iff (!reset_n)
        (q_phase == 4'b0001 && is_move && instr_word[7:0] == INDF0_ADDR) |-> ##1 rd_req.addr == $past(fsr0))
        else $error("indirect source not resolved");

    // Quarter phase is always one-hot
    chk_phase_onehot: assert property (@(posedge clk) disable iff (!reset_n)
        $onehot(q_phase)) else $error("phase not one-hot");

    // Round wraps from the fourth quarter to the first
    chk_phase_wrap: assert property (@(posedge clk) disable iff (!reset_n)
        q_phase == 4'b1000 |=> q_phase == 4'b0001) else $error("phase did not wrap");

    // Direct source address passes unchanged, working register included
    chk_direct_src: assert property (@(posedge clk) disable iff (!reset_n)
        (q_phase == 4'b0001 && is_move && instr_word[7:0] != INDF0_ADDR && instr_word[7:0] != INDF1_ADDR)
        |-> ##1 rd_req.addr == $past(instr_word[7:0]))
        else $error("direct source address wrong");

    // Direct destination address comes from the five window bits
    chk_direct_dst: assert property (@(posedge clk) disable iff (!reset_n)
        (q_phase == 4'b0001 && is_move && instr_word[12:8] != 5'h00 && instr_word[12:8] != 5'h08)
        |-> ##3 wr_req.addr == {3'h0, $past(instr_word[12:8], 3)})
        else $error("direct destination address wrong");

    // Completion is a single-cycle pulse
    chk_done_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        instr_done |=> !instr_done) else $error("done held too long");

    // Unrecognised words complete nothing
    chk_refuse_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        (q_phase == 4'b0001 && !(is_move || is_bank)) |-> ##4 !instr_done)
        else $error("foreign word completed");

    // Bank select only changes on a bank-low load
    chk_bank_only_load: assert property (@(posedge clk) disable iff (!reset_n)
        (q_phase == 4'b0001 && !is_bank) |-> ##4 $stable(bank_select_reg))
        else $error("bank changed without load");

    // Read and write strobes never overlap
    chk_strobe_apart: assert property (@(posedge clk) disable iff (!reset_n)
        !(rd_req.en && wr_req.en)) else $error("read and write together");

    // Main scenarios reached
    cov_move: cover property (@(posedge clk) disable iff (!reset_n) wr_req.en);
    cov_refused: cover property (@(posedge clk) disable iff (!reset_n)
        q_phase == 4'b0001 && instr_valid && !is_move && !is_bank);
    cov_bank: cover property (@(posedge clk) disable iff (!reset_n)
        $changed(bank_select_reg[3:0]));
    cov_work_src: cover property (@(posedge clk) disable iff (!reset_n)
        rd_req.en && rd_req.addr == WORK_ADDR);
endmodule
`default_nettype wire

// File: verif/file_periph_move_bank_low_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Drives the move and bank-low instructions through one Q1..Q4 round each
module file_periph_move_bank_low_exec_tb_top
    import periph_move_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [7:0]  fsr0 = 8'h00;
    logic [7:0]  fsr1 = 8'h00;
    logic [7:0]  rd_data = 8'h00;
    mem_req_t    rd_req;
    mem_req_t    wr_req;
    logic [7:0]  bank_select_reg;
    logic [3:0]  q_phase;
    logic        instr_done;
    logic        flags_we;
    int          n_errors = 0;
    int          tests_run = 0;

    file_periph_move_bank_low_exec dut (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .fsr0(fsr0), .fsr1(fsr1), .rd_data(rd_data), .rd_req(rd_req),
        .wr_req(wr_req), .bank_select_reg(bank_select_reg), .q_phase(q_phase),
        .instr_done(instr_done), .flags_we(flags_we));

    // Free-running 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    // Counts, then the verdict
    task automatic test_done;
        $display("tests_run %0d n_errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic step;
        @(negedge clk);
    endtask

    // Byte compare, four-state exact
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Waits for a Q1 cycle, presents the word, returns at the Q2 negedge
    task automatic issue(input logic [15:0] w, input logic [7:0] d);
        int i;
        for (i = 0; i < 8 && q_phase !== 4'b0001; i++) step;
        if (i == 8) begin
            n_errors++;
            test_done;
        end
        instr_valid = 1'b1;
        instr_word  = w;
        rd_data     = d;
        step;
        instr_valid = 1'b0;
        instr_word  = ~w;
    endtask

    // One move round: read in Q2, write in Q4, done in the next Q1
    task automatic mv(input logic [4:0] p, input logic [7:0] f, input logic [7:0] ra, input logic [7:0] wa,
                      input logic [7:0] d);
        issue({MOVE_OP_CODE, p, f}, d);
        chk("q_phase", 8'h02, {4'h0, q_phase});
        chk("rd_en", 8'h01, {7'h00, rd_req.en});
        chk("rd_addr", ra, rd_req.addr);
        step;
        rd_data = ~d;
        step;
        chk("wr_en", 8'h01, {7'h00, wr_req.en});
        chk("wr_addr", wa, wr_req.addr);
        chk("wr_data", d, wr_req.data);
        chk("flags_we", 8'h00, {7'h00, flags_we});
        step;
        chk("done", 8'h01, {7'h00, instr_done});
    endtask

    task automatic t_direct;
        mv(5'h1F, 8'hFF, 8'hFF, 8'h1F, 8'hA5);
        mv(5'h00 + 5'h13, 8'h45, 8'h45, 8'h13, 8'h3C);
        $display("test direct moves done");
    endtask

    task automatic t_work;
        mv(5'h0A, 8'h21, 8'h21, WORK_ADDR, 8'h5A);
        mv(5'h05, WORK_ADDR, WORK_ADDR, 8'h05, 8'hC3);
        $display("test working register done");
    endtask

    task automatic t_indirect;
        fsr0 = 8'h77;
        fsr1 = 8'h15;
        mv(INDF1_ADDR[4:0], INDF0_ADDR, 8'h77, 8'h15, 8'h96);
        mv(INDF0_ADDR[4:0], INDF1_ADDR, 8'h15, 8'h77, 8'h69);
        $display("test indirect done");
    endtask

    // Bank-low loads back to back, nonzero ignored field
    task automatic t_bank(input logic [15:0] w, input logic [7:0] exp);
        issue(w, 8'h00);
        chk("rd_en", 8'h00, {7'h00, rd_req.en});
        step;
        step;
        chk("wr_en", 8'h00, {7'h00, wr_req.en});
        step;
        chk("bank", exp, bank_select_reg);
        chk("done", 8'h01, {7'h00, instr_done});
        $display("test bank low done");
    endtask

    // Foreign opcode in Q1, valid word outside Q1: nothing happens
    task automatic t_refuse;
        issue(16'hBA57, 8'h00);
        instr_valid = 1'b1;
        instr_word  = 16'hB803;
        step;
        step;
        instr_valid = 1'b0;
        step;
        chk("done", 8'h00, {7'h00, instr_done});
        chk("bank", 8'h0A, bank_select_reg);
        $display("test refused done");
    endtask

    // Reset for 12 cycles, then the scenarios
    initial begin
        repeat (12) step;
        reset_n = 1'b1;
        chk("bank_rst", BANK_RESET, bank_select_reg);
        t_direct;
        t_work;
        t_indirect;
        t_bank(16'hB8F5, 8'h05);
        t_bank(16'hB80A, 8'h0A);
        t_refuse;
        test_done;
    end
endmodule
`default_nettype wire
